// >>> hdl/swr_top.sv
// Supervisor watchdog and reset generator with Wishbone registers
`timescale 1ns/10ps
`default_nettype none
`include "swr_cfg.svh"
module swr_top #(
   parameter int unsigned INT_TICK_CYC = `SWR_INT_TICK_CYC,
   parameter logic [`SWR_CNT_W-1:0] RST_TICKS_INT =
      `SWR_CNT_W'(`SWR_INT_RST_TICKS),
   parameter logic [`SWR_CNT_W-1:0] WDT_SLOW_INT =
      `SWR_CNT_W'(`SWR_INT_WDT_SLOW),
   parameter logic [`SWR_CNT_W-1:0] WDT_FAST_INT =
      `SWR_CNT_W'(`SWR_INT_WDT_FAST),
   parameter logic [`SWR_CNT_W-1:0] RST_CYC_EXT = `SWR_EXT_RST_CYC,
   parameter logic [`SWR_CNT_W-1:0] WDT_CYC_EXT = `SWR_EXT_WDT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire swr_pkg::swr_kick_s watchdog_kick_in_i,
   input wire logic osc_source_select_i,
   input wire logic ext_osc_input_i,
   input wire logic lowline_below_i,
   input wire logic powerfail_below_i,
   input wire logic supply_below_batt_i,
   input wire logic battery_feed_i,
   input wire logic chip_select_n_i,
   output logic reset_n_o,
   output logic reset_o,
   output logic lowline_flag_n_o,
   output logic watchdog_expired_n_o,
   output logic powerfail_flag_n_o,
   output logic battery_active_flag_o,
   output logic chip_select_n_o
);
   import swr_pkg::*;

   function automatic swr_cnt_t swr_pick(
      input logic ext,
      input swr_cnt_t ext_v,
      input swr_cnt_t int_v
   );
      swr_pick = ext ? ext_v : int_v;
   endfunction : swr_pick

   // Timebase and kick front end
   wire tick;
   wire kick_edge;
   wire kick_ok;

   swr_timebase #(
      .INT_TICK_CYC(INT_TICK_CYC)
   ) u_timebase (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .osc_source_select_i(osc_source_select_i),
      .ext_osc_input_i(ext_osc_input_i),
      .tick_o(tick)
   );

   swr_kick_detect u_kick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .kick_i(watchdog_kick_in_i),
      .edge_o(kick_edge),
      .valid_o(kick_ok)
   );

   // State
   swr_rst_state_e state;
   swr_rst_state_e next_state;
   swr_cnt_t pulse_cnt;
   swr_cnt_t next_pulse_cnt;
   swr_cnt_t wdt_cnt;
   swr_cnt_t next_wdt_cnt;
   swr_flags_s flags;
   swr_flags_s next_flags;
   logic wdt_en;
   logic next_wdt_en;
   swr_irq_t irq_stat;
   swr_irq_t next_irq_stat;
   swr_irq_t irq_mask;
   swr_irq_t next_irq_mask;
   logic next_irq;

   // Terminal counts per oscillator option
   wire ext_sel;
   wire [`SWR_CNT_W-1:0] wdt_int_term;
   wire [`SWR_CNT_W-1:0] wdt_term;
   wire [`SWR_CNT_W-1:0] rst_term;

   assign ext_sel = ~osc_source_select_i;
   // Open external input reads high and gives the long default period
   assign wdt_int_term = ext_osc_input_i ? WDT_SLOW_INT :
      WDT_FAST_INT;
   assign wdt_term = swr_pick(ext_sel, WDT_CYC_EXT, wdt_int_term);
   assign rst_term = swr_pick(ext_sel, RST_CYC_EXT, RST_TICKS_INT);

   // Watchdog timer
   wire wdt_on;
   wire wdt_clear;
   wire [`SWR_CNT_W-1:0] wdt_plus;
   wire wdt_hit;

   // Software enable and a valid kick level are both needed
   assign wdt_on = wdt_en & kick_ok;
   assign wdt_plus = wdt_cnt + `SWR_CNT_W'(1);
   assign wdt_hit = wdt_on & tick & ~kick_edge & ~lowline_below_i &
      (wdt_plus >= wdt_term);
   assign wdt_clear = ~wdt_on | kick_edge | lowline_below_i |
      wdt_hit;
   assign next_wdt_cnt = wdt_clear ? `SWR_CNT_W'(0) :
      (tick ? wdt_plus : wdt_cnt);

   // Reset pulse sequencer
   wire [`SWR_CNT_W-1:0] pulse_plus;
   wire pulse_done;

   assign pulse_plus = pulse_cnt + `SWR_CNT_W'(1);
   assign pulse_done = tick & (pulse_plus >= rst_term);

   always_comb begin
      next_state = state;
      next_pulse_cnt = pulse_cnt;
      if (lowline_below_i) begin
         next_state = SWR_LOWLINE;
         next_pulse_cnt = `SWR_CNT_W'(0);
      end else begin
         case (state)
            SWR_LOWLINE: begin
               next_state = SWR_PULSE;
               next_pulse_cnt = `SWR_CNT_W'(0);
            end
            SWR_PULSE: begin
               if (wdt_hit) begin
                  next_pulse_cnt = `SWR_CNT_W'(0);
               end else if (pulse_done) begin
                  next_state = SWR_RELEASED;
                  next_pulse_cnt = `SWR_CNT_W'(0);
               end else if (tick) begin
                  next_pulse_cnt = pulse_plus;
               end
            end
            SWR_RELEASED: begin
               if (wdt_hit) begin
                  next_state = SWR_PULSE;
                  next_pulse_cnt = `SWR_CNT_W'(0);
               end
            end
            default: begin
               next_state = SWR_PULSE;
               next_pulse_cnt = `SWR_CNT_W'(0);
            end
         endcase
      end
   end

   // Expired flag: release conditions win over a fresh timeout
   wire next_expired_n;

   assign next_expired_n = (lowline_below_i | ~wdt_on) ? 1'b1 :
      (wdt_hit ? 1'b0 :
      (kick_edge ? 1'b1 : flags.expired_n));

   // Output flags
   wire next_reset_n;

   assign next_reset_n = (next_state == SWR_RELEASED);

   always_comb begin
      next_flags.reset_n = next_reset_n;
      next_flags.reset = ~next_reset_n;
      next_flags.lowline_n = ~lowline_below_i;
      next_flags.expired_n = next_expired_n;
      next_flags.powerfail_n = ~(powerfail_below_i |
         supply_below_batt_i);
      next_flags.battery_active_flag = battery_feed_i;
      next_flags.cs_n = chip_select_n_i | lowline_below_i;
   end

   assign reset_n_o = flags.reset_n;
   assign reset_o = flags.reset;
   assign lowline_flag_n_o = flags.lowline_n;
   assign watchdog_expired_n_o = flags.expired_n;
   assign powerfail_flag_n_o = flags.powerfail_n;
   assign battery_active_flag_o = flags.battery_active_flag;
   assign chip_select_n_o = flags.cs_n;

   // Wishbone slave: one wait state, writes land on the acknowledged edge
   wire req;
   wire wr_lo;
   wire sel_ctrl;
   wire sel_status;
   wire sel_irq_stat;
   wire sel_irq_mask;
   wire sel_wdt_cnt;
   wire [31:0] status_word;
   wire [31:0] rd_data;

   assign req = wb_cyc_i & wb_stb_i;
   assign wr_lo = req & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign sel_ctrl = (wb_adr_i == `SWR_ADR_CTRL);
   assign sel_status = (wb_adr_i == `SWR_ADR_STATUS);
   assign sel_irq_stat = (wb_adr_i == `SWR_ADR_IRQ_STAT);
   assign sel_irq_mask = (wb_adr_i == `SWR_ADR_IRQ_MASK);
   assign sel_wdt_cnt = (wb_adr_i == `SWR_ADR_WDT_CNT);

   assign status_word = {25'h0, wdt_on, kick_ok, flags.battery_active_flag,
      flags.powerfail_n, flags.lowline_n, flags.expired_n, flags.reset_n};

   // Unmapped addresses acknowledge and read as zero
   assign rd_data = sel_ctrl ? {31'h0, wdt_en} :
      sel_status ? status_word :
      sel_irq_stat ? {28'h0, irq_stat} :
      sel_irq_mask ? {28'h0, irq_mask} :
      sel_wdt_cnt ? {16'h0, wdt_cnt} : 32'h0;

   assign next_wdt_en = (wr_lo & sel_ctrl) ? wb_dat_i[0] : wdt_en;
   assign next_irq_mask = (wr_lo & sel_irq_mask) ?
      wb_dat_i[`SWR_IRQ_W-1:0] : irq_mask;

   // Interrupt events; a set in the same cycle as its clear is kept
   swr_irq_t irq_ev;
   swr_irq_t irq_w1c;

   always_comb begin
      irq_ev = '0;
      irq_ev[`SWR_IRQ_WDT] = wdt_hit;
      irq_ev[`SWR_IRQ_LOWLINE] = lowline_below_i & flags.lowline_n;
      irq_ev[`SWR_IRQ_PFAIL] = ~next_flags.powerfail_n & flags.powerfail_n;
      irq_ev[`SWR_IRQ_BATT] = battery_feed_i & ~flags.battery_active_flag;
   end

   assign irq_w1c = (wr_lo & sel_irq_stat) ?
      wb_dat_i[`SWR_IRQ_W-1:0] : '0;
   assign next_irq_stat = (irq_stat & ~irq_w1c) | irq_ev;
   assign next_irq = |(next_irq_stat & next_irq_mask);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         wb_dat_o <= (req & ~wb_ack_o) ? rd_data : 32'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdt_en <= `SWR_CTRL_RST;
         irq_mask <= `SWR_IRQ_MASK_RST;
         irq_stat <= '0;
         irq_o <= 1'b0;
      end else begin
         wdt_en <= next_wdt_en;
         irq_mask <= next_irq_mask;
         irq_stat <= next_irq_stat;
         irq_o <= next_irq;
      end
   end

   // Leaving reset behaves like a low-line recovery: a full pulse first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= SWR_PULSE;
         pulse_cnt <= '0;
         wdt_cnt <= '0;
         flags <= 7'b0111101;
      end else begin
         state <= next_state;
         pulse_cnt <= next_pulse_cnt;
         wdt_cnt <= next_wdt_cnt;
         flags <= next_flags;
      end
   end
endmodule : swr_top
`default_nettype wire

// >>> hdl/swr_cfg.svh
// Constants for the supervisor watchdog reset block
// Functional notes
// - Kick steady past timeout pulses reset low and drives expired flag low
// - Watchdog timer is disabled while the kick input floats or sits mid-level
// - Every kick transition restarts the timer; processor must kick before timeout
// - A low expired flag returns high at the next kick transition
// - Expired flag held high while the kick input is floating or mid-level
// - Expired flag forced high whenever the low-line flag goes low
// - Active-high reset output is always the inverse of active-low reset
// - Gated chip select low only when incoming select low and sense above threshold
// - Select high or open uses internal oscillator; low uses external input
// - With internal oscillator, external input level picks fast or slow timeout
// - Low-line flag low while sense below threshold, high again with no delay
// - Supply below battery disables power-fail compare and drives its flag low
// - Battery flag high while output fed from battery, low from main supply
// - Active-low reset driven low whenever low-line sense is below threshold
// - Reset held for a 50 ms pulse after the low-line condition clears
// - Default internal timing: kick every 1.6 s or get repeated 50 ms pulses
`ifndef SWR_CFG_SVH
`define SWR_CFG_SVH
`define SWR_CLK_MHZ 125
`define SWR_INT_TICK_US 1000
`define SWR_INT_TICK_CYC (`SWR_INT_TICK_US * `SWR_CLK_MHZ)
`define SWR_RESET_PULSE_MS 50
`define SWR_WDT_SLOW_MS 1600
`define SWR_WDT_FAST_MS 100
`define SWR_INT_RST_TICKS ((`SWR_RESET_PULSE_MS * 1000) / `SWR_INT_TICK_US)
`define SWR_INT_WDT_SLOW ((`SWR_WDT_SLOW_MS * 1000) / `SWR_INT_TICK_US)
`define SWR_INT_WDT_FAST ((`SWR_WDT_FAST_MS * 1000) / `SWR_INT_TICK_US)
`define SWR_EXT_RST_CYC 16'h00c8
`define SWR_EXT_WDT_CYC 16'h1900
`define SWR_CNT_W 16
`define SWR_IRQ_W 4
`define SWR_ADR_CTRL 8'h00
`define SWR_ADR_STATUS 8'h04
`define SWR_ADR_IRQ_STAT 8'h08
`define SWR_ADR_IRQ_MASK 8'h0c
`define SWR_ADR_WDT_CNT 8'h10
`define SWR_CTRL_RST 1'h1
`define SWR_IRQ_MASK_RST 4'h0
`define SWR_IRQ_WDT 0
`define SWR_IRQ_LOWLINE 1
`define SWR_IRQ_PFAIL 2
`define SWR_IRQ_BATT 3
`endif

// >>> hdl/swr_pkg.sv
// Types shared by the supervisor watchdog reset block
`include "swr_cfg.svh"
package swr_pkg;
   typedef enum logic [1:0] {
      SWR_RELEASED = 2'b00,
      SWR_LOWLINE = 2'b01,
      SWR_PULSE = 2'b10
   } swr_rst_state_e;

   typedef struct packed {
      logic valid;
      logic level;
   } swr_kick_s;

   typedef struct packed {
      logic reset_n;
      logic reset;
      logic lowline_n;
      logic expired_n;
      logic powerfail_n;
      logic battery_active_flag;
      logic cs_n;
   } swr_flags_s;

   typedef logic [`SWR_IRQ_W-1:0] swr_irq_t;
   typedef logic [`SWR_CNT_W-1:0] swr_cnt_t;
endpackage : swr_pkg

// >>> hdl/swr_timebase.sv
// Tick generator from internal divider or external oscillator input
`timescale 1ns/10ps
`default_nettype none
`include "swr_cfg.svh"
module swr_timebase #(
   parameter int unsigned INT_TICK_CYC = `SWR_INT_TICK_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic osc_source_select_i,
   input wire logic ext_osc_input_i,
   output logic tick_o
);
   logic [31:0] div;
   logic ext_prev;
   wire div_end;
   wire ext_rise;
   wire next_tick;

   assign div_end = (div >= INT_TICK_CYC - 32'h1);
   assign ext_rise = ext_osc_input_i & ~ext_prev;
   // Divider keeps running so a switch back to internal is glitch free
   assign next_tick = osc_source_select_i ? div_end : ext_rise;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div <= 32'h0;
         ext_prev <= 1'b0;
         tick_o <= 1'b0;
      end else begin
         div <= div_end ? 32'h0 : div + 32'h1;
         ext_prev <= ext_osc_input_i;
         tick_o <= next_tick;
      end
   end
endmodule : swr_timebase
`default_nettype wire

// >>> hdl/swr_kick_detect.sv
// Edge detector for the three-level watchdog kick input
`timescale 1ns/10ps
`default_nettype none
module swr_kick_detect (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire swr_pkg::swr_kick_s kick_i,
   output logic edge_o,
   output logic valid_o
);
   import swr_pkg::*;
   logic prev_level;
   logic prev_valid;
   wire next_edge;

   // Entering the valid band is no transition, only a level change inside it
   assign next_edge = kick_i.valid & prev_valid &
      (kick_i.level != prev_level);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_level <= 1'b0;
         prev_valid <= 1'b0;
         edge_o <= 1'b0;
         valid_o <= 1'b0;
      end else begin
         prev_level <= kick_i.level;
         prev_valid <= kick_i.valid;
         edge_o <= next_edge;
         valid_o <= kick_i.valid;
      end
   end
endmodule : swr_kick_detect
`default_nettype wire

// >>> verification/swr_top_monitor.sv
// Port checker for the supervisor watchdog block
`timescale 1ns/10ps
`default_nettype none
module swr_top_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire swr_pkg::swr_kick_s watchdog_kick_in_i,
   input wire logic lowline_below_i,
   input wire logic powerfail_below_i,
   input wire logic supply_below_batt_i,
   input wire logic battery_feed_i,
   input wire logic chip_select_n_i,
   input wire logic reset_n_o,
   input wire logic reset_o,
   input wire logic lowline_flag_n_o,
   input wire logic watchdog_expired_n_o,
   input wire logic powerfail_flag_n_o,
   input wire logic battery_active_flag_o,
   input wire logic chip_select_n_o
);
   import swr_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   rst_inverse_a: assert property (reset_o == !reset_n_o)
      else $error("reset outputs not inverse");
   cs_gate_a: assert property (!$past(rst_i) |->
      chip_select_n_o == $past(chip_select_n_i | lowline_below_i))
      else $error("chip select gating wrong");
   lowline_follow_a: assert property (!$past(rst_i) |->
      lowline_flag_n_o == !$past(lowline_below_i))
      else $error("low-line flag wrong");
   pfail_follow_a: assert property (!$past(rst_i) |->
      powerfail_flag_n_o == !$past(powerfail_below_i | supply_below_batt_i))
      else $error("power-fail flag wrong");
   batt_follow_a: assert property (!$past(rst_i) |->
      battery_active_flag_o == $past(battery_feed_i))
      else $error("battery flag wrong");
   lowline_reset_a: assert property ($past(lowline_below_i) |->
      !reset_n_o)
      else $error("reset not held by low line");
   float_quiet_a: assert property (!watchdog_kick_in_i.valid [*3] |=>
      watchdog_expired_n_o)
      else $error("expired flag low while kick floats");
   lowline_clear_a: assert property (lowline_below_i [*3] |=>
      watchdog_expired_n_o)
      else $error("expired flag low during low line");
   expire_reset_a: assert property ($fell(watchdog_expired_n_o) |->
      !reset_n_o)
      else $error("timeout without reset pulse");
   cover property ($fell(watchdog_expired_n_o));
   cover property ($rose(reset_n_o));
   cover property (lowline_below_i ##1 !reset_n_o);
endmodule : swr_top_monitor
bind swr_top swr_top_monitor u_swr_top_monitor (
   .clk_i(clk_i), .rst_i(rst_i), .watchdog_kick_in_i(watchdog_kick_in_i),
   .lowline_below_i(lowline_below_i), .powerfail_below_i(powerfail_below_i),
   .supply_below_batt_i(supply_below_batt_i),
   .battery_feed_i(battery_feed_i), .chip_select_n_i(chip_select_n_i),
   .reset_n_o(reset_n_o), .reset_o(reset_o),
   .lowline_flag_n_o(lowline_flag_n_o),
   .watchdog_expired_n_o(watchdog_expired_n_o),
   .powerfail_flag_n_o(powerfail_flag_n_o),
   .battery_active_flag_o(battery_active_flag_o),
   .chip_select_n_o(chip_select_n_o));
`default_nettype wire

// >>> verification/swr_cpu_model.sv
// Processor model that services the three-level kick input
`timescale 1ns/10ps
`default_nettype none
module swr_cpu_model #(
   parameter int PERIOD = 30
) (
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic float_i,
   input wire logic poke_i,
   output wire swr_pkg::swr_kick_s kick_o
);
   import swr_pkg::*;
   int cnt = 0;
   logic lvl = 1'b0;
   logic junk = 1'b0;
   // Kicks well inside the timeout so a healthy run never resets
   always @(posedge clk_i) begin
      junk <= !junk;
      cnt <= (run_i && cnt < PERIOD) ? cnt + 1 : 0;
      if ((run_i && cnt == PERIOD) || poke_i) begin
         lvl <= !lvl;
      end
   end
   // A floating pin has no trustworthy level, so it wanders each cycle
   assign kick_o = float_i ? {1'b0, junk} : {1'b1, lvl};
endmodule : swr_cpu_model
`default_nettype wire

// >>> verification/swr_top_tb.sv
// Self-checking bench for the supervisor watchdog block
`timescale 1ns/10ps
`default_nettype none
`include "swr_cfg.svh"
module swr_top_tb;
   import swr_pkg::*;
   localparam int TCK = 10;
   localparam int RT = 4;
   localparam int WF = 10;
   localparam int WS = 20;
   localparam int WX = 20;
   typedef struct packed {logic [4:0] i; logic [3:0] e;} swr_row_s;
   swr_row_s rows [6] = '{'{5'h00, 4'hc}, '{5'h01, 4'hd}, '{5'h10, 4'h5},
      '{5'h08, 4'h8}, '{5'h06, 4'ha}, '{5'h02, 4'he}};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, we = 1'b0, ack, irq, osel = 1'b1, ext = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic lb = 1'b0, pb = 1'b0, sb = 1'b0, bf = 1'b0, csi = 1'b1;
   logic rn, ro, lln, exn, pfn, bat, cso;
   logic run = 1'b0, flt = 1'b1, poke = 1'b0, ext_run = 1'b0, ext_lvl = 1'b0;
   logic [1:0] ext_cnt = 2'h0;
   swr_kick_s kick;
   int n_mismatch = 0, check_count = 0, n, m;
   always #4 clk_i = !clk_i;
   always @(posedge clk_i) begin
      ext_cnt <= ext_cnt + 2'h1;
      if (!ext_run) ext <= ext_lvl;
      else if (ext_cnt == 2'h3) ext <= !ext;
   end
   swr_top #(.INT_TICK_CYC(TCK), .RST_TICKS_INT(16'(RT)),
      .WDT_SLOW_INT(16'(WS)), .WDT_FAST_INT(16'(WF)),
      .RST_CYC_EXT(16'h0004), .WDT_CYC_EXT(16'(WX))) u_swr_top (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
      .watchdog_kick_in_i(kick), .osc_source_select_i(osel),
      .ext_osc_input_i(ext), .lowline_below_i(lb),
      .powerfail_below_i(pb), .supply_below_batt_i(sb),
      .battery_feed_i(bf), .chip_select_n_i(csi), .reset_n_o(rn),
      .reset_o(ro), .lowline_flag_n_o(lln), .watchdog_expired_n_o(exn),
      .powerfail_flag_n_o(pfn), .battery_active_flag_o(bat),
      .chip_select_n_o(cso));
   swr_cpu_model #(.PERIOD(30)) u_swr_cpu_model (.clk_i(clk_i),
      .run_i(run), .float_i(flt), .poke_i(poke), .kick_o(kick));
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      // The ack is expected on the second edge; a lost ack ends in the watchdog
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      check("ack", k, 2);
   endtask : wb
   // Counts cycles until reset (k=0) or expired (k=1) reaches v
   task automatic wait_on(int k, logic v, output int c);
      c = 0;
      while ((k ? exn : rn) !== v && c < 1000) begin
         @(posedge clk_i);
         c++;
      end
   endtask : wait_on
   task automatic kick_once;
      poke <= 1'b1;
      @(posedge clk_i);
      poke <= 1'b0;
   endtask : kick_once
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   initial begin
      #80000;
      n_mismatch++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[r]) begin
         {lb, pb, sb, bf, csi} <= rows[r].i;
         repeat (2) @(posedge clk_i);
         check("flags", {lln, pfn, bat, cso}, rows[r].e);
      end
      $display("flag table done");
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check("reset pins", {rn, ro}, 2'b01);
      rst_i <= 1'b0;
      wait_on(0, 1'b1, n);
      check("pulse len", n >= (RT-1)*TCK && n <= (RT+1)*TCK+3, 1);
      wb(1'b1, 8'h20, 32'hffffffff);
      wb(1'b0, 8'h20, 0);
      check("unmapped", q, 0);
      wb(1'b0, `SWR_ADR_CTRL, 0);
      check("ctrl", q, 1);
      wb(1'b0, `SWR_ADR_STATUS, 0);
      check("status", q, 32'h1f);
      $display("reset test done");
      flt <= 1'b0;
      run <= 1'b1;
      n = 0;
      repeat (300) begin
         @(posedge clk_i);
         n += (rn !== 1'b1 || exn !== 1'b1);
      end
      check("kicked", n, 0);
      run <= 1'b0;
      kick_once();
      wait_on(1, 1'b0, n);
      check("fast timeout", n >= (WF-1)*TCK && n <= (WF+1)*TCK+3, 1);
      check("timeout rst", rn, 0);
      wait_on(0, 1'b1, n);
      wait_on(0, 1'b0, m);
      check("repeat", n+m >= (WF-1)*TCK && n+m <= (WF+1)*TCK, 1);
      check("still expired", exn, 0);
      wb(1'b0, `SWR_ADR_IRQ_STAT, 0);
      check("irq stat", {q[0], irq}, 2'b10);
      wb(1'b1, `SWR_ADR_IRQ_MASK, 1);
      repeat (2) @(posedge clk_i);
      check("irq on", irq, 1);
      kick_once();
      wait_on(1, 1'b1, n);
      check("kick clears", n < 5, 1);
      run <= 1'b1;
      wb(1'b1, `SWR_ADR_IRQ_STAT, 1);
      repeat (2) @(posedge clk_i);
      check("irq off", irq, 0);
      $display("fast watchdog done");
      ext_lvl <= 1'b1;
      run <= 1'b0;
      kick_once();
      wait_on(1, 1'b0, n);
      check("slow timeout", n >= (WS-1)*TCK && n <= (WS+1)*TCK+3, 1);
      lb <= 1'b1;
      repeat (4) @(posedge clk_i);
      check("lowline", {exn, rn}, 2'b10);
      lb <= 1'b0;
      flt <= 1'b1;
      n = 0;
      repeat (300) begin
         @(posedge clk_i);
         n += (exn !== 1'b1);
      end
      check("float", {n[30:0], rn}, 32'h1);
      $display("disable test done");
      osel <= 1'b0;
      ext_run <= 1'b1;
      flt <= 1'b0;
      kick_once();
      wait_on(1, 1'b0, n);
      check("ext timeout", n >= (WX-1)*8 && n <= (WX+1)*8+4, 1);
      wb(1'b1, `SWR_ADR_CTRL, 0);
      wb(1'b0, `SWR_ADR_STATUS, 0);
      check("wdt off", q[6:1], 6'h1f);
      wb(1'b0, `SWR_ADR_WDT_CNT, 0);
      check("wdt cnt", q, 0);
      $display("external clock done");
      complete_run();
   end
endmodule : swr_top_tb
`default_nettype wire
